// *** rxq_defs.vh ***
`ifndef RXQ_DEFS_VH
`define RXQ_DEFS_VH

// Register addresses on the internal I2C register port
`define RXQ_ADDR_PORT_SEL 8'h4c
`define RXQ_ADDR_STS_ONE 8'h4d
`define RXQ_ADDR_STS_TWO 8'h4e
`define RXQ_ADDR_CAM_STS 8'h7a
`define RXQ_ADDR_EQ_CTL 8'hd2
`define RXQ_ADDR_EQ_BYPASS 8'hd4
`define RXQ_ADDR_EQ_LIMITS 8'hd5
`define RXQ_ADDR_RSVD_D6 8'hd6
`define RXQ_ADDR_RSVD_D7 8'hd7
`define RXQ_ADDR_IRQ_EN_HI 8'hd8
`define RXQ_ADDR_IRQ_EN_LO 8'hd9

// Reset values
`define RXQ_RST_PORT_SEL 8'h00
`define RXQ_RST_EQ_CTL 8'h94
`define RXQ_RST_EQ_BYPASS 8'h60
`define RXQ_RST_EQ_LIMITS 8'hf2
`define RXQ_RST_RSVD 8'h00
`define RXQ_RST_IRQ_EN 8'h00

// Writable masks
`define RXQ_MASK_EQ_CTL 8'hf4
`define RXQ_MASK_IRQ_EN_HI 8'h07
`define RXQ_MASK_PORT_SEL 8'h03

// Field positions
`define RXQ_BIT_BYPASS 0
`define RXQ_BIT_FLOOR_EN 2
`define RXQ_BIT_RESTART 3

// Event vector layout: bits 6:0 follow low enable, 9:7 follow high enable
`define RXQ_NUM_EVT 10
`define RXQ_EVT_LOCK 0
`define RXQ_EVT_VALID 1
`define RXQ_EVT_PARITY 2
`define RXQ_EVT_CAMERA 3
`define RXQ_EVT_OVERFLOW 4
`define RXQ_EVT_LINE_CNT 5
`define RXQ_EVT_LINE_LEN 6
`define RXQ_EVT_CRC 7
`define RXQ_EVT_SEQ 8
`define RXQ_EVT_ENC 9

// Events cleared by a read of each status register
`define RXQ_CLR_STS_ONE 10'h187
`define RXQ_CLR_STS_TWO 10'h270
`define RXQ_CLR_CAM_STS 10'h008

`endif

// *** rxq_port_regs.v ***
`timescale 1ns/1ps
`include "rxq_defs.vh"

// One receive port's copy of the equalizer and enable registers
module rxq_port_regs (
  input wire clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire wr_en, // Write aimed at this port
  input wire [7:0] addr, // Register address
  input wire [7:0] wdata, // Write data
  output reg [7:0] eq_ctl_ff, // Equalizer control
  output reg [7:0] eq_bypass_ff, // Manual bypass register
  output reg [7:0] eq_limits_ff, // Upper limit and floor
  output reg [7:0] rsvd_d6_ff, // Spare byte
  output reg [7:0] rsvd_d7_ff, // Spare byte
  output reg [7:0] irq_en_hi_ff, // High enable mask
  output reg [7:0] irq_en_lo_ff, // Low enable mask
  output reg restart_ff // One-cycle adaptation restart
);

  // Stored fields; restart bit is self-clearing so it never stores
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      eq_ctl_ff <= `RXQ_RST_EQ_CTL; // [R6]
      eq_bypass_ff <= `RXQ_RST_EQ_BYPASS;
      eq_limits_ff <= `RXQ_RST_EQ_LIMITS; // [R3] [R5]
      rsvd_d6_ff <= `RXQ_RST_RSVD;
      rsvd_d7_ff <= `RXQ_RST_RSVD;
      irq_en_hi_ff <= `RXQ_RST_IRQ_EN; // [R19]
      irq_en_lo_ff <= `RXQ_RST_IRQ_EN; // [R19]
      restart_ff <= 1'b0;
    end
    else
    begin
      restart_ff <= wr_en && (addr == `RXQ_ADDR_EQ_CTL) && wdata[`RXQ_BIT_RESTART];
      if (wr_en)
      begin
        case (addr)
          `RXQ_ADDR_EQ_CTL: eq_ctl_ff <= wdata & `RXQ_MASK_EQ_CTL;
          `RXQ_ADDR_EQ_BYPASS: eq_bypass_ff <= wdata;
          `RXQ_ADDR_EQ_LIMITS: eq_limits_ff <= wdata;
          `RXQ_ADDR_RSVD_D6: rsvd_d6_ff <= wdata;
          `RXQ_ADDR_RSVD_D7: rsvd_d7_ff <= wdata;
          `RXQ_ADDR_IRQ_EN_HI: irq_en_hi_ff <= wdata & `RXQ_MASK_IRQ_EN_HI; // [R20]
          `RXQ_ADDR_IRQ_EN_LO: irq_en_lo_ff <= wdata;
          default: ;
        endcase
      end
    end
  end

endmodule

// *** rxq_irq_port.v ***
`timescale 1ns/1ps
`include "rxq_defs.vh"

// Sticky event flags for one port; the enable mask gates only the interrupt
module rxq_irq_port #(
  parameter NE = `RXQ_NUM_EVT
) (
  input wire clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire [NE-1:0] evt, // Event pulses
  input wire [NE-1:0] clr, // Clear-on-read strobes
  input wire [NE-1:0] en, // Enable mask
  output reg [NE-1:0] pend_ff, // Pending flags
  output reg irq_ff // Port interrupt
);

  wire [NE-1:0] nxt_pend;

  // Set wins over clear so an event in the read cycle survives
  assign nxt_pend = evt | (pend_ff & ~clr); // [R18]

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pend_ff <= {NE{1'b0}};
      irq_ff <= 1'b0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      irq_ff <= |(nxt_pend & en); // [R19]
    end
  end

endmodule

// *** rxq_eq_irq_top.v ***
`timescale 1ns/1ps
`include "rxq_defs.vh"

// How it works
// R1: Bypass takes low setting bits from 3:1
// R2: Bypass takes high setting bits from 7:5
// R3: Adaptive value never exceeds upper limit
// R4: Software keeps upper limit above floor
// R5: Floor enable starts adaptation at floor
// R6: Floor start enable resets to one
// R7: Port select routes accesses to copy
// R8: High bit 2 enables encoding error
// R9: High bit 1 enables sequence error
// R10: High bit 0 enables checksum error
// R11: Low bit 6 enables line length change
// R12: Low bit 5 enables line count change
// R13: Low bit 4 enables buffer overflow
// R14: Low bit 3 enables camera receiver error
// R15: Low bit 2 enables parity error
// R16: Low bit 1 enables valid change
// R17: Low bit 0 enables lock change
// R18: Status register read clears pending events
// R19: Interrupt needs pending and enable; off at reset
// R20: High reserved bits read zero
module rxq_eq_irq_top #(
  parameter NP = 2
) (
  input wire clk, // 40 MHz system clock
  input wire rst_n, // Synchronous reset, active low
  input wire reg_wr_en, // Register write strobe
  input wire reg_rd_en, // Register read strobe
  input wire [7:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Register write data
  output reg [7:0] reg_rdata_ff, // Read data, one cycle after strobe
  output reg reg_rvalid_ff, // Read data valid pulse
  input wire [NP-1:0] link_encoding_error, // Encoding error pulses
  input wire [NP-1:0] ctrl_channel_sequence, // Control channel sequence error pulses
  input wire [NP-1:0] ctrl_channel_checksum, // Control channel checksum error pulses
  input wire [NP-1:0] line_length_change, // Line length change pulses
  input wire [NP-1:0] line_count_change, // Line count change pulses
  input wire [NP-1:0] rx_overflow, // Receive buffer overflow pulses
  input wire [NP-1:0] camera_rx_error, // Camera receiver error pulses
  input wire [NP-1:0] link_parity_error, // Parity error pulses
  input wire [NP-1:0] port_valid, // Port valid level
  input wire [NP-1:0] rx_lock, // Receiver lock level
  input wire [4*NP-1:0] eq_adapt_code, // Engine's requested gain code
  output wire [NP-1:0] eq_adaptation_disable, // Adaptation bypassed
  output wire [NP-1:0] eq_floor_start_enable, // Start from floor
  output wire [4*NP-1:0] eq_start_code, // Code adaptation begins at
  output reg [6*NP-1:0] eq_setting_ff, // Applied equalizer setting
  output wire [NP-1:0] eq_restart, // Adaptation restart pulse
  output wire [NP-1:0] port_irq, // Per-port interrupt
  output reg irq_any_ff // Any port interrupting
);

  // Pick the flags that one status register reports
  function [7:0] sts_byte;
    input [7:0] addr;
    input [`RXQ_NUM_EVT-1:0] pend;
    input lock_lvl;
    input valid_lvl;
    begin
      case (addr)
        `RXQ_ADDR_STS_ONE:
          sts_byte = {valid_lvl, lock_lvl, 1'b0, pend[`RXQ_EVT_SEQ], pend[`RXQ_EVT_CRC],
                      pend[`RXQ_EVT_PARITY], pend[`RXQ_EVT_VALID], pend[`RXQ_EVT_LOCK]};
        `RXQ_ADDR_STS_TWO:
          sts_byte = {4'h0, pend[`RXQ_EVT_OVERFLOW], pend[`RXQ_EVT_LINE_CNT],
                      pend[`RXQ_EVT_LINE_LEN], pend[`RXQ_EVT_ENC]};
        `RXQ_ADDR_CAM_STS:
          sts_byte = {7'h00, pend[`RXQ_EVT_CAMERA]};
        default:
          sts_byte = 8'h00;
      endcase
    end
  endfunction

  // Which pending flags a read of the given address clears
  function [`RXQ_NUM_EVT-1:0] clr_mask;
    input [7:0] addr;
    begin
      case (addr)
        `RXQ_ADDR_STS_ONE: clr_mask = `RXQ_CLR_STS_ONE;
        `RXQ_ADDR_STS_TWO: clr_mask = `RXQ_CLR_STS_TWO;
        `RXQ_ADDR_CAM_STS: clr_mask = `RXQ_CLR_CAM_STS;
        default: clr_mask = {`RXQ_NUM_EVT{1'b0}};
      endcase
    end
  endfunction

  // Limit the engine's request to the programmed ceiling
  function [3:0] clamp_code;
    input [3:0] req;
    input [3:0] upper;
    begin
      if (req > upper)
        clamp_code = upper;
      else
        clamp_code = req;
    end
  endfunction

  // Manual setting: stage-one field on top, stage-two field below
  function [5:0] manual_setting;
    input [7:0] byp;
    begin
      manual_setting = {byp[7:5], byp[3:1]};
    end
  endfunction

  // Port select register; shared by all ports
  reg [7:0] port_sel_ff;
  wire [1:0] sel_idx;

  always @(posedge clk)
  begin
    if (!rst_n)
      port_sel_ff <= `RXQ_RST_PORT_SEL;
    else if (reg_wr_en && (reg_addr == `RXQ_ADDR_PORT_SEL))
      port_sel_ff <= reg_wdata & `RXQ_MASK_PORT_SEL;
  end

  assign sel_idx = port_sel_ff[1:0];

  // Per-port register copies, flags and level history
  wire [8*NP-1:0] eq_ctl_w;
  wire [8*NP-1:0] eq_bypass_w;
  wire [8*NP-1:0] eq_limits_w;
  wire [8*NP-1:0] rsvd_d6_w;
  wire [8*NP-1:0] rsvd_d7_w;
  wire [8*NP-1:0] irq_en_hi_w;
  wire [8*NP-1:0] irq_en_lo_w;
  wire [`RXQ_NUM_EVT*NP-1:0] pend_w;
  wire [8*NP-1:0] port_rbyte;
  reg [NP-1:0] lock_prev_ff;
  reg [NP-1:0] valid_prev_ff;
  wire [6*NP-1:0] nxt_eq_setting;

  // Remember last levels so either edge of lock or valid is an event
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      lock_prev_ff <= {NP{1'b0}};
      valid_prev_ff <= {NP{1'b0}};
    end
    else
    begin
      lock_prev_ff <= rx_lock;
      valid_prev_ff <= port_valid;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp = gp + 1)
    begin : g_port
      wire hit;
      wire [`RXQ_NUM_EVT-1:0] evt;
      wire [`RXQ_NUM_EVT-1:0] clr;
      wire [`RXQ_NUM_EVT-1:0] en;
      wire [7:0] ctl;
      wire [7:0] byp;
      wire [7:0] lim;
      wire [7:0] ehi;
      wire [7:0] elo;
      wire [3:0] req;
      wire [3:0] upper;
      wire [3:0] floor;
      wire [3:0] clamped;
      wire [`RXQ_NUM_EVT-1:0] pend;
      wire [5:0] nxt_setting;

      // Only the selected port's copy sees accesses
      assign hit = ({30'h0, sel_idx} == gp); // [R7]

      // Detector inputs mapped onto the event vector
      assign evt[`RXQ_EVT_LOCK] = rx_lock[gp] ^ lock_prev_ff[gp]; // [R17]
      assign evt[`RXQ_EVT_VALID] = port_valid[gp] ^ valid_prev_ff[gp]; // [R16]
      assign evt[`RXQ_EVT_PARITY] = link_parity_error[gp]; // [R15]
      assign evt[`RXQ_EVT_CAMERA] = camera_rx_error[gp]; // [R14]
      assign evt[`RXQ_EVT_OVERFLOW] = rx_overflow[gp]; // [R13]
      assign evt[`RXQ_EVT_LINE_CNT] = line_count_change[gp]; // [R12]
      assign evt[`RXQ_EVT_LINE_LEN] = line_length_change[gp]; // [R11]
      assign evt[`RXQ_EVT_CRC] = ctrl_channel_checksum[gp]; // [R10]
      assign evt[`RXQ_EVT_SEQ] = ctrl_channel_sequence[gp]; // [R9]
      assign evt[`RXQ_EVT_ENC] = link_encoding_error[gp]; // [R8]

      // Reading a status register clears only that port's flags
      assign clr = (reg_rd_en && hit) ? clr_mask(reg_addr) : {`RXQ_NUM_EVT{1'b0}}; // [R18]

      // Enable bits line up with the event vector
      assign en = {ehi[2:0], elo[6:0]}; // [R8] [R17]

      rxq_port_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && hit), // [R7]
        .addr(reg_addr),
        .wdata(reg_wdata),
        .eq_ctl_ff(ctl),
        .eq_bypass_ff(byp),
        .eq_limits_ff(lim),
        .rsvd_d6_ff(rsvd_d6_w[8*gp+7:8*gp]),
        .rsvd_d7_ff(rsvd_d7_w[8*gp+7:8*gp]),
        .irq_en_hi_ff(ehi),
        .irq_en_lo_ff(elo),
        .restart_ff(eq_restart[gp])
      );

      rxq_irq_port #(
        .NE(`RXQ_NUM_EVT)
      ) u_irq (
        .clk(clk),
        .rst_n(rst_n),
        .evt(evt),
        .clr(clr),
        .en(en),
        .pend_ff(pend),
        .irq_ff(port_irq[gp])
      );

      assign eq_ctl_w[8*gp+7:8*gp] = ctl;
      assign eq_bypass_w[8*gp+7:8*gp] = byp;
      assign eq_limits_w[8*gp+7:8*gp] = lim;
      assign irq_en_hi_w[8*gp+7:8*gp] = ehi;
      assign irq_en_lo_w[8*gp+7:8*gp] = elo;
      assign pend_w[`RXQ_NUM_EVT*gp+`RXQ_NUM_EVT-1:`RXQ_NUM_EVT*gp] = pend;

      // Equalizer controls straight from the register flops
      assign upper = lim[7:4];
      assign floor = lim[3:0];
      assign eq_adaptation_disable[gp] = byp[`RXQ_BIT_BYPASS];
      assign eq_floor_start_enable[gp] = ctl[`RXQ_BIT_FLOOR_EN]; // [R6]

      // Start code is the floor only when enabled, else zero
      assign eq_start_code[4*gp+3:4*gp] = ctl[`RXQ_BIT_FLOOR_EN] ? floor : 4'h0; // [R5]

      // Clamp guards the line even if the engine overshoots
      assign req = eq_adapt_code[4*gp+3:4*gp];
      assign clamped = clamp_code(req, upper); // [R3]

      // Next applied setting: manual fields when bypassed, clamped code otherwise
      assign nxt_setting = byp[`RXQ_BIT_BYPASS] ? manual_setting(byp) // [R1] [R2]
                                                : {2'b00, clamped}; // [R3]
      assign nxt_eq_setting[6*gp+5:6*gp] = nxt_setting;

      // This port's answer, taken from the wide register copies
      assign port_rbyte[8*gp+7:8*gp] = rd_port_byte(
        reg_addr,
        eq_ctl_w[8*gp+7:8*gp],
        eq_bypass_w[8*gp+7:8*gp],
        eq_limits_w[8*gp+7:8*gp],
        rsvd_d6_w[8*gp+7:8*gp],
        rsvd_d7_w[8*gp+7:8*gp],
        irq_en_hi_w[8*gp+7:8*gp],
        irq_en_lo_w[8*gp+7:8*gp],
        pend_w[`RXQ_NUM_EVT*gp+`RXQ_NUM_EVT-1:`RXQ_NUM_EVT*gp],
        rx_lock[gp],
        port_valid[gp]
      );
    end
  endgenerate

  // One process owns the whole setting bus, so no bit has two drivers
  always @(posedge clk)
  begin
    if (!rst_n)
      eq_setting_ff <= {6*NP{1'b0}};
    else
      eq_setting_ff <= nxt_eq_setting; // [R1] [R2] [R3]
  end

  // Read decode for the port-specific block; restart always reads zero
  function [7:0] rd_port_byte;
    input [7:0] addr;
    input [7:0] ctl;
    input [7:0] byp;
    input [7:0] lim;
    input [7:0] d6;
    input [7:0] d7;
    input [7:0] ehi;
    input [7:0] elo;
    input [`RXQ_NUM_EVT-1:0] pend;
    input lock_lvl;
    input valid_lvl;
    begin
      case (addr)
        `RXQ_ADDR_EQ_CTL: rd_port_byte = ctl & `RXQ_MASK_EQ_CTL;
        `RXQ_ADDR_EQ_BYPASS: rd_port_byte = byp;
        `RXQ_ADDR_EQ_LIMITS: rd_port_byte = lim;
        `RXQ_ADDR_RSVD_D6: rd_port_byte = d6;
        `RXQ_ADDR_RSVD_D7: rd_port_byte = d7;
        `RXQ_ADDR_IRQ_EN_HI: rd_port_byte = ehi & `RXQ_MASK_IRQ_EN_HI; // [R20]
        `RXQ_ADDR_IRQ_EN_LO: rd_port_byte = elo;
        default: rd_port_byte = sts_byte(addr, pend, lock_lvl, valid_lvl);
      endcase
    end
  endfunction

  // Route the selected port's byte; an absent port reads zero
  reg [7:0] sel_byte;
  integer k;

  always @*
  begin
    sel_byte = 8'h00;
    for (k = 0; k < NP; k = k + 1)
    begin
      if (sel_idx == k[1:0])
        sel_byte = port_rbyte[8*k+7 -: 8]; // [R7]
    end
  end

  // Registered read answer; unmapped addresses return zero
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rvalid_ff <= reg_rd_en;
      if (reg_rd_en)
      begin
        if (reg_addr == `RXQ_ADDR_PORT_SEL)
          reg_rdata_ff <= port_sel_ff;
        else
          reg_rdata_ff <= sel_byte;
      end
    end
  end

  // Combined line lags port lines by one cycle
  always @(posedge clk)
  begin
    if (!rst_n)
      irq_any_ff <= 1'b0;
    else
      irq_any_ff <= |port_irq; // [R19]
  end

endmodule

// *** rxq_assertions.sv ***
`timescale 1ns/1ps
`include "rxq_defs.vh"

// Port-level checks; port 0 carries the equalizer checks
module rxq_assertions #(
  parameter NP = 2
) (
  input wire clk, // System clock
  input wire rst_n, // Sync reset, active low
  input wire reg_wr_en, // Write strobe
  input wire reg_rd_en, // Read strobe
  input wire [7:0] reg_addr, // Address
  input wire [7:0] reg_wdata, // Write data
  input wire [7:0] reg_rdata_ff, // Read data
  input wire reg_rvalid_ff, // Read valid
  input wire [4*NP-1:0] eq_adapt_code, // Engine request
  input wire [NP-1:0] eq_adaptation_disable, // Bypass level
  input wire [NP-1:0] eq_floor_start_enable, // Floor start level
  input wire [4*NP-1:0] eq_start_code, // Start code
  input wire [6*NP-1:0] eq_setting_ff, // Applied setting
  input wire [NP-1:0] eq_restart, // Restart pulse
  input wire [NP-1:0] port_irq, // Port interrupts
  input wire irq_any_ff // Combined interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Plain copies so the history functions see whole signals
  wire [3:0] code_p0 = eq_adapt_code[3:0];
  wire restart_bit = reg_wdata[`RXQ_BIT_RESTART];

  property p_rvalid; reg_rd_en |=> reg_rvalid_ff; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid missing");
  property p_rvalid_only; !reg_rd_en |=> !reg_rvalid_ff; endproperty
  a_rvalid_only: assert property (p_rvalid_only) else $error("stray read valid");
  property p_rdata_hold; !reg_rvalid_ff |-> $stable(reg_rdata_ff); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // Clamp can only lower the request, never raise it
  property p_clamp;
    !eq_adaptation_disable[0] |=> eq_setting_ff[5:0] <= {2'b00, $past(code_p0)};
  endproperty
  a_clamp: assert property (p_clamp) else $error("setting above request");
  property p_start_zero; !eq_floor_start_enable[0] |-> eq_start_code[3:0] == 4'h0; endproperty
  a_start_zero: assert property (p_start_zero) else $error("start not zero");
  property p_restart;
    eq_restart[0] |-> $past(reg_wr_en) && $past(reg_addr) == `RXQ_ADDR_EQ_CTL && $past(restart_bit);
  endproperty
  a_restart: assert property (p_restart) else $error("restart without write");
  property p_irq_any; |port_irq |=> irq_any_ff; endproperty
  a_irq_any: assert property (p_irq_any) else $error("combined irq missing");
  property p_irq_any_off; !(|port_irq) |=> !irq_any_ff; endproperty
  a_irq_any_off: assert property (p_irq_any_off) else $error("combined irq stuck");
  // A read drops the line next edge; an enable write takes one edge longer
  property p_irq_fall; $fell(port_irq[0]) |-> $past(reg_rd_en) || $past(reg_wr_en, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped unasked");

  c_irq: cover property ($rose(port_irq[0]));
  c_restart: cover property (eq_restart[0]);
  c_bypass: cover property (eq_adaptation_disable[1]);
endmodule

// *** rxq_far_model.sv ***
`timescale 1ns/1ps
`include "rxq_defs.vh"

// Far link end: event pulses and lock/valid levels, port p at [10p+9:10p]
module rxq_far_model #(
  parameter NP = 2
) (
  input wire clk, // System clock
  output reg [`RXQ_NUM_EVT*NP-1:0] evt_ff // Event lines
);
  initial evt_ff = '0;

  // Levels toggle and stay; error lines pulse for exactly one cycle
  task fire(input integer k, input integer p);
    begin
      @(posedge clk);
      #1;
      evt_ff[10*p+k] = ~evt_ff[10*p+k];
      @(posedge clk);
      #1;
      if (k > 1)
        evt_ff[10*p+k] = 1'b0;
    end
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "rxq_defs.vh"

// Self-checking bench for the port register and interrupt block
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg [7:0] code = 8'h00;
  wire [7:0] rdata;
  wire rvalid;
  wire [19:0] e;
  wire [1:0] dis, flo, rsp, irq;
  wire [7:0] start;
  wire [11:0] setting;
  wire irq_any;
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;

  always #12.5 clk = ~clk;

  rxq_far_model #(.NP(2)) i_far (.clk(clk), .evt_ff(e));

  rxq_eq_irq_top #(.NP(2)) i_dut (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_ff(rdata),
    .reg_rvalid_ff(rvalid), .rx_lock({e[10], e[0]}), .port_valid({e[11], e[1]}),
    .link_parity_error({e[12], e[2]}), .camera_rx_error({e[13], e[3]}),
    .rx_overflow({e[14], e[4]}), .line_count_change({e[15], e[5]}),
    .line_length_change({e[16], e[6]}), .ctrl_channel_checksum({e[17], e[7]}),
    .ctrl_channel_sequence({e[18], e[8]}), .link_encoding_error({e[19], e[9]}),
    .eq_adapt_code(code), .eq_adaptation_disable(dis), .eq_floor_start_enable(flo),
    .eq_start_code(start), .eq_setting_ff(setting), .eq_restart(rsp), .port_irq(irq),
    .irq_any_ff(irq_any));

  task complete_run;
    begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wait_n(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      wait_n(1);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      wait_n(1);
      wr_en = 1'b0;
    end
  endtask

  task rdc(input [7:0] a, input [7:0] exp);
    begin
      wait_n(1);
      rd_en = 1'b1;
      addr = a;
      wait_n(1);
      rd_en = 1'b0;
      chk(rvalid, 1'b1);
      chk(rdata, exp);
    end
  endtask

  task t_reset;
    begin
      rdc(`RXQ_ADDR_EQ_BYPASS, 8'h60);
      rdc(`RXQ_ADDR_EQ_LIMITS, 8'hf2);
      rdc(`RXQ_ADDR_EQ_CTL, 8'h94);
      rdc(`RXQ_ADDR_IRQ_EN_HI, 8'h00);
      rdc(`RXQ_ADDR_IRQ_EN_LO, 8'h00);
      chk(start, 8'h22);
      chk(flo, 2'b11);
      chk(irq, 2'b00);
    end
  endtask

  // Port 1 bypassed, port 0 must stay adaptive
  task t_bypass;
    begin
      wr(`RXQ_ADDR_PORT_SEL, 8'h01);
      wr(`RXQ_ADDR_EQ_BYPASS, 8'ha7);
      wait_n(2);
      chk(setting[11:6], 6'h2b);
      chk(dis, 2'b10);
      wr(`RXQ_ADDR_PORT_SEL, 8'h00);
      rdc(`RXQ_ADDR_EQ_BYPASS, 8'h60);
      wr(`RXQ_ADDR_PORT_SEL, 8'h01);
      wr(`RXQ_ADDR_EQ_BYPASS, 8'h00);
    end
  endtask

  // Upper limit 5 above floor 2 on port 1
  task t_clamp;
    begin
      wr(`RXQ_ADDR_EQ_LIMITS, 8'h52);
      code = 8'h90;
      wait_n(2);
      chk(setting[11:6], 6'h05);
      code = 8'h30;
      wait_n(2);
      chk(setting[11:6], 6'h03);
      chk(start[7:4], 4'h2);
      wr(`RXQ_ADDR_EQ_CTL, 8'h90);
      chk(start[7:4], 4'h0);
      chk(rsp, 2'b00);
      wr(`RXQ_ADDR_EQ_CTL, 8'h9c);
      chk(start[7:4], 4'h2);
      chk(rsp, 2'b10);
      wr(`RXQ_ADDR_PORT_SEL, 8'h00);
      wr(`RXQ_ADDR_EQ_CTL, 8'h9c);
      chk(rsp, 2'b01);
    end
  endtask

  task t_regs;
    begin
      wr(`RXQ_ADDR_IRQ_EN_HI, 8'hff);
      rdc(`RXQ_ADDR_IRQ_EN_HI, 8'h07);
      wr(`RXQ_ADDR_IRQ_EN_HI, 8'h00);
      wr(`RXQ_ADDR_IRQ_EN_LO, 8'h01);
      wr(`RXQ_ADDR_PORT_SEL, 8'h01);
      rdc(`RXQ_ADDR_IRQ_EN_LO, 8'h00);
      wr(`RXQ_ADDR_PORT_SEL, 8'h00);
      rdc(`RXQ_ADDR_IRQ_EN_LO, 8'h01);
      wr(`RXQ_ADDR_IRQ_EN_LO, 8'h00);
    end
  endtask

  // Every event: masked first, then enabled late, then enabled up front
  task t_irq;
    integer k;
    reg [7:0] ea, eb, ca, sa, sb;
    begin
      for (k = 0; k < 10; k = k + 1)
      begin
        ea = (k < 7) ? `RXQ_ADDR_IRQ_EN_LO : `RXQ_ADDR_IRQ_EN_HI;
        eb = (k < 7) ? (8'h01 << k) : (8'h01 << (k - 7));
        if (((`RXQ_CLR_STS_ONE >> k) & 10'h001) != 10'h000)
          ca = `RXQ_ADDR_STS_ONE;
        else if (((`RXQ_CLR_STS_TWO >> k) & 10'h001) != 10'h000)
          ca = `RXQ_ADDR_STS_TWO;
        else
          ca = `RXQ_ADDR_CAM_STS;
        // Status bit of each event; lock and valid levels show after the first toggle
        case (k)
          0, 3, 9: sb = 8'h01;
          1, 6: sb = 8'h02;
          2, 5: sb = 8'h04;
          4, 7: sb = 8'h08;
          default: sb = 8'h10;
        endcase
        sa = sb | ((k == 0) ? 8'h40 : 8'h00) | ((k == 1) ? 8'h80 : 8'h00);
        i_far.fire(k, 0);
        wait_n(1);
        chk(irq, 2'b00);
        wr(ea, eb);
        wait_n(1);
        chk(irq, 2'b01);
        rdc(ca, sa);
        chk(irq_any, 1'b1);
        wait_n(1);
        chk(irq, 2'b00);
        chk(irq_any, 1'b0);
        i_far.fire(k, 0);
        chk(irq, 2'b01);
        rdc(ca, sb);
        wait_n(1);
        chk(irq, 2'b00);
        wr(ea, 8'h00);
      end
    end
  endtask

  initial
  begin
    wait_n(4);
    rst_n = 1'b1;
    t_reset;
    t_bypass;
    t_clamp;
    t_regs;
    t_irq;
    complete_run;
  end
endmodule

bind rxq_eq_irq_top rxq_assertions #(.NP(NP)) i_chk (.clk(clk), .rst_n(rst_n),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
  .eq_adapt_code(eq_adapt_code), .eq_adaptation_disable(eq_adaptation_disable),
  .eq_floor_start_enable(eq_floor_start_enable), .eq_start_code(eq_start_code),
  .eq_setting_ff(eq_setting_ff), .eq_restart(eq_restart), .port_irq(port_irq),
  .irq_any_ff(irq_any_ff));
